// *** logic/trsm_top.sv ***
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module trsm_top #(
   parameter int PERIOD_W = trsm_pkg::PERIOD_W,
   parameter int JITTER_CYC = trsm_pkg::JITTER_LIMIT_CYC,
   parameter int OUT_NUM = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // decoder status inputs
   input wire logic telegramStrobe,
   input wire logic consistencyFail,
   input wire logic carrierPresent,
   input wire logic correctionSettled,
   input wire logic warmedUp,
   input wire logic utcChecksumBad,
   input wire logic configChecksumBad,
   input wire logic [7:0] qualityFigure,
   input wire logic [7:0] inputGain,
   input wire logic [15:0] oscDrift,
   // outputs
   output logic ppsEnable,
   output logic [OUT_NUM-1:0] outputRelease,
   output logic freewheel,
   output logic irq
);
   // *****************************
   // bus front end
   // *****************************
   logic wrStrobe;
   logic [7:0] regAddr;

   trsm_apb apbFront (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pready(pready),
      .pslverr(pslverr),
      .wrStrobe(wrStrobe),
      .rdStrobe(),
      .regAddr(regAddr)
   );

   // *****************************
   // jitter check
   // *****************************
   // the verdict needs three telegrams; before that jitter counts as in limit
   logic jitterValid, jitterExceeded;

   trsm_jitter #(
      .PERIOD_W(PERIOD_W),
      .LIMIT_CYC(JITTER_CYC)
   ) jitterCheck (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .telegramStrobe(telegramStrobe),
      .jitterValid(jitterValid),
      .jitterExceeded(jitterExceeded)
   );

   // *****************************
   // registers
   // *****************************
   logic [7:0] stateQ;
   logic [7:0] configQ;
   logic [15:0] utcOffsetQ;
   logic utcInvalidQ, configInvalidQ;
   logic telegramErrQ, ppsQ, lockSeenQ;
   // event count, fixed by the interrupt status layout
   localparam int IRQ_W = trsm_pkg::IRQ_WIDTH;
   logic [IRQ_W-1:0] irqStatusQ, irqEnableQ;
   logic [OUT_NUM-1:0] outAlwaysQ, releaseQ;
   logic [31:0] prdataQ;
   logic irqQ;
   logic freewheelQ;
   trsm_pkg::trsm_mode_type modeQ, modeD;

   // true when the bus addresses the given register
   function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] target);
      return addr == target;
   endfunction

   // a flag that is set now but was clear in the last state word
   function automatic logic newlySet(input logic nowVal, input logic wasVal);
      return nowVal && !wasVal;
   endfunction

   // write decode: writes act at the access edge, when pready is already high
   // the clear register has no storage; its strobe only masks status bits
   wire logic wrConfig = wrStrobe && addrHit(regAddr, trsm_pkg::ADDR_CONFIG);
   wire logic wrUtc = wrStrobe && addrHit(regAddr, trsm_pkg::ADDR_UTC_OFFSET);
   wire logic wrIrqEn = wrStrobe && addrHit(regAddr, trsm_pkg::ADDR_IRQ_ENABLE);
   wire logic wrIrqClr = wrStrobe && addrHit(regAddr, trsm_pkg::ADDR_IRQ_CLEAR);
   wire logic wrOutCtrl = wrStrobe && addrHit(regAddr, trsm_pkg::ADDR_OUT_CTRL);

   // *****************************
   // receiver mode decisions
   // *****************************
   wire logic ieeeOn = configQ[trsm_pkg::CFG_IEEE1344] && !configInvalidQ;
   wire logic utcBlocks = !ieeeOn && utcInvalidQ;
   wire logic jitterBad = jitterValid && jitterExceeded;
   wire logic badTelegram = telegramStrobe && consistencyFail;
   wire logic dataAvail = carrierPresent;
   // a telegram error stands until the next telegram, so re-sync takes
   // one clean telegram after the faulty one before it is accepted
   wire logic syncOk = dataAvail && !jitterBad && !telegramErrQ && !utcBlocks;
   wire logic lockNow = modeQ == trsm_pkg::TRSM_SYNC && correctionSettled;

   // freewheel whenever a fault stands, otherwise follow telegrams
   always_comb begin
      modeD = modeQ;
      unique case (modeQ)
         trsm_pkg::TRSM_FREEWHEEL: begin
            if (telegramStrobe && syncOk && !consistencyFail) begin
               modeD = trsm_pkg::TRSM_SYNC;
            end
         end
         trsm_pkg::TRSM_SYNC: begin
            if (!syncOk || badTelegram) begin
               modeD = trsm_pkg::TRSM_FREEWHEEL;
            end
         end
      endcase
   end

   // state word assembled from current flags
   logic [7:0] stateD;
   always_comb begin
      stateD = 8'h00;
      stateD[trsm_pkg::BIT_UTC_INVALID] = utcInvalidQ;
      stateD[trsm_pkg::BIT_JITTER] = jitterBad;
      stateD[trsm_pkg::BIT_LOCK] = lockNow;
      stateD[trsm_pkg::BIT_TELEGRAM_ERR] = telegramErrQ;
      stateD[trsm_pkg::BIT_DATA_AVAIL] = dataAvail;
      stateD[trsm_pkg::BIT_CONFIG_INVALID] = configInvalidQ;
      stateD[trsm_pkg::BIT_PULSES_ON] = ppsQ;
      stateD[trsm_pkg::BIT_WARMED_UP] = warmedUp;
   end

   // interrupt events; lock and jitter flags are edge-qualified so a standing fault raises one event
   wire logic [IRQ_W-1:0] irqEvent = {newlySet(lockNow, stateQ[trsm_pkg::BIT_LOCK]), badTelegram,
      newlySet(jitterBad, stateQ[trsm_pkg::BIT_JITTER]), telegramStrobe};

   // output release: always, or once synchronised and locked
   wire logic [OUT_NUM-1:0] releaseD = releaseQ | outAlwaysQ | {OUT_NUM{lockNow}};

   // *****************************
   // read data selection
   // *****************************
   // each register zero-extended to the bus width
   wire logic [31:0] rdState = {24'h000000, stateQ};
   wire logic [31:0] rdConfig = {24'h000000, configQ};
   wire logic [31:0] rdUtc = {16'h0000, utcOffsetQ};
   wire logic [31:0] rdQuality = {16'h0000, inputGain, qualityFigure};
   wire logic [31:0] rdDrift = {16'h0000, oscDrift};
   wire logic [31:0] rdIrqStatus = 32'(irqStatusQ);
   wire logic [31:0] rdIrqEnable = 32'(irqEnableQ);
   wire logic [31:0] rdOutCtrl = 32'(outAlwaysQ);

   // select by address; unmapped offsets and the write-only clear read as zero
   wire logic [31:0] rdData =
      addrHit(regAddr, trsm_pkg::ADDR_STATE) ? rdState :
      addrHit(regAddr, trsm_pkg::ADDR_CONFIG) ? rdConfig :
      addrHit(regAddr, trsm_pkg::ADDR_UTC_OFFSET) ? rdUtc :
      addrHit(regAddr, trsm_pkg::ADDR_QUALITY) ? rdQuality :
      addrHit(regAddr, trsm_pkg::ADDR_DRIFT) ? rdDrift :
      addrHit(regAddr, trsm_pkg::ADDR_IRQ_STATUS) ? rdIrqStatus :
      addrHit(regAddr, trsm_pkg::ADDR_IRQ_ENABLE) ? rdIrqEnable :
      addrHit(regAddr, trsm_pkg::ADDR_OUT_CTRL) ? rdOutCtrl :
      32'h0000_0000;

   // read data is captured at the setup edge so it stands through the access phase
   wire logic setupPhase = psel && !penable;

   // *****************************
   // status flags and mode
   // *****************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         modeQ <= trsm_pkg::TRSM_FREEWHEEL;
         freewheelQ <= 1'b1;
         stateQ <= 8'h00;
         utcInvalidQ <= 1'b0;
         configInvalidQ <= 1'b0;
         telegramErrQ <= 1'b0;
         ppsQ <= 1'b0;
         lockSeenQ <= 1'b0;
      end else begin
         modeQ <= modeD;
         // freewheel output registered from the next mode, so it tracks modeQ exactly
         freewheelQ <= modeD == trsm_pkg::TRSM_FREEWHEEL;
         stateQ <= stateD;
         // a checksum error wins over a software write in the same cycle
         if (utcChecksumBad) begin
            utcInvalidQ <= 1'b1;
         end else if (wrUtc) begin
            utcInvalidQ <= 1'b0;
         end
         if (configChecksumBad) begin
            configInvalidQ <= 1'b1;
         end else if (wrConfig) begin
            configInvalidQ <= 1'b0;
         end
         if (badTelegram) begin
            telegramErrQ <= 1'b1;
         end else if (telegramStrobe) begin
            telegramErrQ <= 1'b0;
         end
         if (lockNow && !lockSeenQ) begin
            ppsQ <= 1'b1;
            lockSeenQ <= 1'b1;
         end
      end
   end

   // *****************************
   // software registers
   // *****************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         configQ <= trsm_pkg::CFG_DEFAULT;
         utcOffsetQ <= 16'h0000;
         irqEnableQ <= '0;
         outAlwaysQ <= '0;
      end else begin
         if (configChecksumBad) begin
            configQ <= trsm_pkg::CFG_DEFAULT;
         end else if (wrConfig) begin
            configQ <= pwdata[7:0] & trsm_pkg::CFG_USED_MASK;
         end
         if (wrUtc) begin
            utcOffsetQ <= pwdata[15:0];
         end
         if (wrIrqEn) begin
            irqEnableQ <= pwdata[IRQ_W-1:0];
         end
         if (wrOutCtrl) begin
            outAlwaysQ <= pwdata[OUT_NUM-1:0];
         end
      end
   end

   // *****************************
   // interrupts, outputs, read data
   // *****************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irqStatusQ <= '0;
         irqQ <= 1'b0;
         releaseQ <= '0;
         prdataQ <= 32'h0000_0000;
      end else begin
         irqStatusQ <= (irqStatusQ & ~(wrIrqClr ? pwdata[IRQ_W-1:0] : '0)) | irqEvent; // set wins
         irqQ <= |(irqStatusQ & irqEnableQ);
         releaseQ <= releaseD;
         if (setupPhase) begin
            prdataQ <= rdData;
         end
      end
   end

   assign prdata = prdataQ;
   assign ppsEnable = ppsQ;
   assign outputRelease = releaseQ;
   assign freewheel = freewheelQ;
   assign irq = irqQ;
endmodule

// *** logic/trsm_pkg.sv ***
package trsm_pkg;
   // *****************************
   // register map (byte addresses)
   // *****************************
   localparam logic [7:0] ADDR_STATE = 8'h00;
   localparam logic [7:0] ADDR_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_UTC_OFFSET = 8'h08;
   localparam logic [7:0] ADDR_QUALITY = 8'h0C;
   localparam logic [7:0] ADDR_DRIFT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h1C;
   localparam logic [7:0] ADDR_OUT_CTRL = 8'h20;

   // *****************************
   // state word bit positions
   // *****************************
   localparam int BIT_UTC_INVALID = 7;
   localparam int BIT_JITTER = 6;
   localparam int BIT_LOCK = 5;
   localparam int BIT_TELEGRAM_ERR = 4;
   localparam int BIT_DATA_AVAIL = 3;
   localparam int BIT_CONFIG_INVALID = 2;
   localparam int BIT_PULSES_ON = 1;
   localparam int BIT_WARMED_UP = 0;

   // *****************************
   // configuration word fields
   // *****************************
   localparam int CFG_IGNORE_DOY = 3;
   localparam int CFG_IGNORE_QUALITY = 2;
   localparam int CFG_IGNORE_SYNC = 1;
   localparam int CFG_IEEE1344 = 0;
   localparam logic [7:0] CFG_USED_MASK = 8'h0F;
   localparam logic [7:0] CFG_DEFAULT = 8'h00;

   // *****************************
   // interrupt event positions
   // *****************************
   localparam int IRQ_TELEGRAM = 0;
   localparam int IRQ_JITTER = 1;
   localparam int IRQ_TELEGRAM_ERR = 2;
   localparam int IRQ_LOCK = 3;
   localparam int IRQ_WIDTH = 4;

   // *****************************
   // timing
   // *****************************
   localparam int CLK_MHZ = 200;
   localparam int JITTER_LIMIT_US = 100;
   localparam int JITTER_LIMIT_CYC = JITTER_LIMIT_US * CLK_MHZ;
   localparam int PERIOD_W = 32;

   typedef enum logic { // one bit, so both codes are legal modes
      TRSM_FREEWHEEL,
      TRSM_SYNC
   } trsm_mode_type;
endpackage

// *** logic/trsm_jitter.sv ***
`timescale 1ns/10ps
// *****************************
// telegram period and jitter check
// *****************************
module trsm_jitter #(
   parameter int PERIOD_W = trsm_pkg::PERIOD_W,
   parameter int LIMIT_CYC = trsm_pkg::JITTER_LIMIT_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // telegram boundary
   input wire logic telegramStrobe,
   // result
   output logic jitterValid,
   output logic jitterExceeded
);
   logic [PERIOD_W-1:0] countQ, countD;
   logic [PERIOD_W-1:0] lastPeriodQ;
   logic [1:0] seenQ;
   logic exceededQ;
   logic [PERIOD_W-1:0] diff;
   wire logic [PERIOD_W-1:0] limit = PERIOD_W'(LIMIT_CYC);

   // absolute difference between current and previous period
   assign diff = (countQ > lastPeriodQ) ? countQ - lastPeriodQ : lastPeriodQ - countQ;
   assign countD = telegramStrobe ? '0 : countQ + PERIOD_W'(1);
   assign jitterValid = seenQ[1];
   assign jitterExceeded = exceededQ;

   // period counter and comparison on each telegram from the third on
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         countQ <= '0;
         lastPeriodQ <= '0;
         seenQ <= 2'h0;
         exceededQ <= 1'b0;
      end else begin
         countQ <= countD;
         if (telegramStrobe) begin
            lastPeriodQ <= countQ;
            seenQ <= {seenQ[0], 1'b1};
            if (seenQ[1]) begin
               exceededQ <= diff > limit;
            end
         end
      end
   end
endmodule

// *** logic/trsm_apb.sv ***
`timescale 1ns/10ps
// *****************************
// apb slave front end, zero wait state
// *****************************
module trsm_apb (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   output logic pready,
   output logic pslverr,
   // register side
   output logic wrStrobe,
   output logic rdStrobe,
   output logic [7:0] regAddr
);
   wire logic access = psel && !penable;

   // answer in the access phase right after setup
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
      end else begin
         pready <= access;
      end
   end

   assign pslverr = 1'b0;
   assign wrStrobe = psel && penable && pready && pwrite;
   assign rdStrobe = psel && penable && pready && !pwrite;
   assign regAddr = paddr;
endmodule

// *** tb/trsm_checker.sv ***
`timescale 1ns/10ps
// *****************************
// port checks of the status monitor
// *****************************
module trsm_checker #(
   parameter int OUT_NUM = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // receiver side
   input wire logic telegramStrobe,
   input wire logic consistencyFail,
   input wire logic carrierPresent,
   input wire logic correctionSettled,
   input wire logic [7:0] qualityFigure,
   input wire logic [7:0] inputGain,
   // outputs
   input wire logic ppsEnable,
   input wire logic [OUT_NUM-1:0] outputRelease,
   input wire logic freewheel
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // read phases of a transfer
   wire logic setupRd = psel && !penable && !pwrite;
   wire logic accessRd = psel && penable && pready && !pwrite;

   chk_pps_sticky: assert property (ppsEnable |=> ppsEnable)
      else $error("pulse output switched off");
   chk_pps_cause: assert property ($rose(ppsEnable) |-> $past(correctionSettled) || $past(correctionSettled, 2))
      else $error("pulse output on without settled correction");
   chk_release_kept: assert property (1'b1 |=> (outputRelease & $past(outputRelease)) == $past(outputRelease))
      else $error("output release withdrawn");
   chk_release_sync: assert property (ppsEnable |-> ##[0:2] (&outputRelease))
      else $error("outputs not released after lock");
   chk_tgerr_freewheel: assert property (telegramStrobe && consistencyFail |-> ##[1:2] freewheel)
      else $error("no freewheel after telegram error");
   chk_sync_carrier: assert property ($fell(freewheel) |-> $past(carrierPresent) || $past(carrierPresent, 2))
      else $error("synchronised without time code");
   chk_state_width: assert property (accessRd && paddr == trsm_pkg::ADDR_STATE |-> prdata[31:8] == 24'h000000)
      else $error("state word wider than eight bits");
   chk_cfg_reserved: assert property (accessRd && paddr == trsm_pkg::ADDR_CONFIG |-> prdata[31:4] == 28'h0000000)
      else $error("reserved configuration bits set");
   chk_quality_read: assert property (setupRd && paddr == trsm_pkg::ADDR_QUALITY
      |=> prdata[15:0] == {$past(inputGain), $past(qualityFigure)})
      else $error("quality and gain read wrong");
endmodule

bind trsm_top trsm_checker #(.OUT_NUM(OUT_NUM)) u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .telegramStrobe(telegramStrobe), .consistencyFail(consistencyFail), .carrierPresent(carrierPresent),
   .correctionSettled(correctionSettled), .qualityFigure(qualityFigure), .inputGain(inputGain),
   .ppsEnable(ppsEnable), .outputRelease(outputRelease), .freewheel(freewheel));

// *** tb/trsm_source.sv ***
`timescale 1ns/10ps
// *****************************
// time code source model
// *****************************
module trsm_source (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // control from the bench
   input wire logic run,
   input wire logic [15:0] period,
   input wire logic failNext,
   // decoded telegram side
   output logic telegramStrobe,
   output logic consistencyFail,
   output logic carrierPresent,
   output logic [15:0] tgCount
);
   logic [15:0] tick;
   // one telegram every period cycles; fail flag is junk between telegrams
   always @(posedge sys_clk) begin
      if (sys_rst || !run) begin
         tick <= 16'h0000;
         telegramStrobe <= 1'b0;
         consistencyFail <= 1'b0;
         carrierPresent <= 1'b0;
      end else begin
         carrierPresent <= 1'b1;
         tick <= (tick + 16'h0001 >= period) ? 16'h0000 : tick + 16'h0001;
         telegramStrobe <= (tick == 16'h0000);
         consistencyFail <= (tick == 16'h0000) ? failNext : !failNext;
      end
      if (sys_rst) begin
         tgCount <= 16'h0000;
      end else if (run && tick == 16'h0000) begin
         tgCount <= tgCount + 16'h0001;
      end
   end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
// *****************************
// testbench of the status monitor
// *****************************
module tb_top;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, ppsEnable, freewheel, irq, telegramStrobe, consistencyFail, carrierPresent;
   logic [3:0] outputRelease;
   logic settled = 1'b1, warm = 1'b1, utcBad = 1'b0, cfgBad = 1'b0, run = 1'b0, failNext = 1'b0;
   logic [15:0] period = 16'h0064, tgCount;
   int fails = 0, checkCount = 0;
   // 200 MHz clock
   always #2.5 sys_clk = ~sys_clk;

   trsm_top #(.JITTER_CYC(50)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .telegramStrobe(telegramStrobe), .consistencyFail(consistencyFail), .carrierPresent(carrierPresent),
      .correctionSettled(settled), .warmedUp(warm), .utcChecksumBad(utcBad), .configChecksumBad(cfgBad),
      .qualityFigure(8'h5A), .inputGain(8'hC3), .oscDrift(16'h1234), .ppsEnable(ppsEnable),
      .outputRelease(outputRelease), .freewheel(freewheel), .irq(irq));
   trsm_source src (.sys_clk(sys_clk), .sys_rst(sys_rst), .run(run), .period(period), .failNext(failNext),
      .telegramStrobe(telegramStrobe), .consistencyFail(consistencyFail), .carrierPresent(carrierPresent),
      .tgCount(tgCount));

   // *****************************
   // report, compare and bus tasks
   // *****************************
   task wrapUp();
      $display("checks %0d mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
         fails++;
         wrapUp();
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      cmp(q & m, e);
   endtask
   // wait for n telegrams, settle two cycles
   task waitTg(input int n);
      int k;
      int seen;
      seen = 0;
      for (k = 0; k < 5000 && seen < n; k++) begin
         @(negedge sys_clk);
         if (telegramStrobe === 1'b1) seen++;
      end
      if (seen < n) begin
         fails++;
         wrapUp();
      end
      repeat (2) @(negedge sys_clk);
   endtask

   // *****************************
   // main sequence
   // *****************************
   initial begin
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(trsm_pkg::ADDR_STATE, 32'h01, 32'hFF);
      apb(1'b1, trsm_pkg::ADDR_CONFIG, 32'hFFFFFFFF);
      rd(trsm_pkg::ADDR_CONFIG, 32'h0F, 32'hFFFFFFFF);
      @(posedge sys_clk);
      cfgBad <= 1'b1;
      @(posedge sys_clk);
      cfgBad <= 1'b0;
      rd(trsm_pkg::ADDR_CONFIG, 32'h00, 32'hFFFFFFFF);
      rd(trsm_pkg::ADDR_STATE, 32'h04, 32'h04);
      apb(1'b1, trsm_pkg::ADDR_CONFIG, 32'h0);
      rd(trsm_pkg::ADDR_STATE, 32'h00, 32'h04);
      utcBad <= 1'b1;
      @(posedge sys_clk);
      utcBad <= 1'b0;
      rd(trsm_pkg::ADDR_STATE, 32'h80, 32'h80);
      apb(1'b1, trsm_pkg::ADDR_OUT_CTRL, 32'h1);
      repeat (2) @(negedge sys_clk);
      cmp({28'h0, outputRelease}, 32'h1);
      run <= 1'b1;
      waitTg(5);
      cmp({30'h0, freewheel, ppsEnable}, 32'h2);
      apb(1'b1, trsm_pkg::ADDR_UTC_OFFSET, 32'h12);
      rd(trsm_pkg::ADDR_STATE, 32'h00, 32'h80);
      waitTg(2);
      rd(trsm_pkg::ADDR_STATE, 32'h2B, 32'hFF);
      cmp({27'h0, outputRelease, freewheel}, 32'h1E);
      // correction unsettled and cold: lock and warm bits drop, pulses stay on
      settled <= 1'b0;
      warm <= 1'b0;
      rd(trsm_pkg::ADDR_STATE, 32'h02, 32'h23);
      settled <= 1'b1;
      warm <= 1'b1;
      // lock event: raise, mask, clear
      rd(trsm_pkg::ADDR_IRQ_STATUS, 32'h08, 32'h08);
      cmp({31'h0, irq}, 32'h0);
      apb(1'b1, trsm_pkg::ADDR_IRQ_ENABLE, 32'h8);
      repeat (2) @(negedge sys_clk);
      cmp({31'h0, irq}, 32'h1);
      apb(1'b1, trsm_pkg::ADDR_IRQ_CLEAR, 32'h8);
      repeat (2) @(negedge sys_clk);
      cmp({31'h0, irq}, 32'h0);
      rd(trsm_pkg::ADDR_QUALITY, 32'hC35A, 32'hFFFF);
      rd(trsm_pkg::ADDR_DRIFT, 32'h1234, 32'hFFFF);
      rd(8'h3C, 32'h0, 32'hFFFFFFFF);
      cmp({31'h0, pslverr}, 32'h0);
      waitTg(1);
      failNext <= 1'b1;
      waitTg(1);
      failNext <= 1'b0;
      rd(trsm_pkg::ADDR_STATE, 32'h10, 32'h10);
      cmp({31'h0, freewheel}, 32'h1);
      period <= 16'h00C8;
      waitTg(1);
      rd(trsm_pkg::ADDR_STATE, 32'h40, 32'h40);
      waitTg(1);
      rd(trsm_pkg::ADDR_STATE, 32'h00, 32'h40);
      // jitter and telegram error events stay latched
      rd(trsm_pkg::ADDR_IRQ_STATUS, 32'h06, 32'h06);
      // with the 1344 extension on, a bad utc parameter does not block sync
      apb(1'b1, trsm_pkg::ADDR_CONFIG, 32'h1);
      utcBad <= 1'b1;
      @(posedge sys_clk);
      utcBad <= 1'b0;
      waitTg(2);
      cmp({31'h0, freewheel}, 32'h0);
      wrapUp();
   end
endmodule
